// file: hdl/ssb_pkg.sv
/*
  Constants and types shared by the serial port stop-collision, baud
  generator and status block.
  Assumes one 100 MHz system clock and an 8-bit register port.
*/
package ssb_pkg;
  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_RELOAD = 3'h0;
  localparam logic [2:0] REG_BUF    = 3'h1;
  localparam logic [2:0] REG_CTL1   = 3'h2;
  localparam logic [2:0] REG_CTL2   = 3'h3;
  localparam logic [2:0] REG_CTL3   = 3'h4;
  localparam logic [2:0] REG_MASK   = 3'h5;
  localparam logic [2:0] REG_STAT   = 3'h6;
  localparam logic [2:0] REG_EVENT  = 3'h7;
  localparam logic [7:0] REG_RST    = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int C1_WCOL    = 7;
  localparam int C1_OVF     = 6;
  localparam int C1_EN      = 5;
  localparam int C1_CKP     = 4;
  localparam int C2_ACKSTAT = 6;
  localparam int C2_ACK_ENABLE_BIT   = 4;
  localparam int C2_RECEIVE_ENABLE_BIT    = 3;
  localparam int C2_PEN     = 2;
  localparam int C2_RESTART_ENABLE_BIT    = 1;
  localparam int C2_SEN     = 0;
  localparam int EV_BCOL    = 0;
  // ---------------------------------------------------------------
  // Modes and fixed divides
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_SPI_D4   = 4'h0;
  localparam logic [3:0] MODE_SPI_D16  = 4'h1;
  localparam logic [3:0] MODE_SPI_D64  = 4'h2;
  localparam logic [3:0] MODE_I2C_S7   = 4'h6;
  localparam logic [3:0] MODE_I2C_S10  = 4'h7;
  localparam logic [3:0] MODE_I2C_MST  = 4'h8;
  localparam logic [3:0] MODE_SPI_BRG  = 4'hA;
  localparam logic [3:0] MODE_I2C_FW   = 4'hB;
  localparam logic [3:0] MODE_I2C_S7I  = 4'hE;
  localparam logic [3:0] MODE_I2C_S10I = 4'hF;
  localparam logic [7:0] RELOAD_D4     = 8'h00;
  localparam logic [7:0] RELOAD_D16    = 8'h03;
  localparam logic [7:0] RELOAD_D64    = 8'h0F;
  localparam logic [3:0] DATA_LAST     = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_XFER, S_P_SDA, S_P_SCL, S_P_HOLD, S_P_CHK
  } ssb_fsm_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       div;
  } ssb_brg_regs_t;

  typedef struct packed {
    logic [7:0] reload;
    logic [7:0] buf_q;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] mask;
    logic       sample_phase_bit;
    logic       cke;
    logic       da;
    logic       stop_seen;
    logic       start_seen;
    logic       rw;
    logic       ua;
    logic       bf;
    logic       bcol;
    ssb_fsm_t   st;
    logic [3:0] bitn;
    logic       half;
    logic       sbit;
    logic [7:0] shreg;
    logic       sda_low;
    logic       scl_low;
    logic       sck;
    logic       sdo;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] sdi_sync;
    logic       scl_prev;
    logic       sda_prev;
    logic [7:0] rdata;
  } ssb_regs_t;
endpackage : ssb_pkg

// file: hdl/ssb_brg_if.sv
/*
  Link between the port logic and its baud counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface ssb_brg_if;
  logic [7:0] reload;
  logic       run;
  logic       tick;
  modport ctl (output reload, output run, input tick);
  modport gen (input reload, input run, output tick);
endinterface : ssb_brg_if

// file: hdl/ssb_baud_gen.sv
/*
  Baud counter: half-phase ticks of 2*(reload+1) clocks.
  Assumes the reload value only matters while run is low or at a tick.
*/
`timescale 1ns/1ns
module ssb_baud_gen (
  input wire logic mclk,
  input wire logic rst,
  ssb_brg_if.gen   brg
);
  ssb_pkg::ssb_brg_regs_t q_r;
  ssb_pkg::ssb_brg_regs_t q_nxt;

  // -----------------------------------------------------------------
  // Count down on every second clock, reload at zero
  // -----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    if (!brg.run) begin
      q_nxt.cnt = brg.reload;
      q_nxt.div = 1'b0;
    end else begin
      q_nxt.div = ~q_r.div;
      if (q_r.div) begin
        q_nxt.cnt = (q_r.cnt == 8'h00) ? brg.reload : q_r.cnt - 8'h01;
      end
    end
  end

  assign brg.tick = brg.run & q_r.div & (q_r.cnt == 8'h00);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : ssb_baud_gen

// file: hdl/ssb_port.sv
/*
  Serial port core: register file, shared I2C/SPI bit engine, Stop
  sequence with bus collision detection, and bus condition status.
  Assumes open-drain I2C pads resolved outside, slave address logic
  supplying the slv_* pulses on mclk, and software keeping to the
  limits on reload values and sample phase.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Stop: after SDA release and count expiry, SDA low means collision.
// - Stop: SCL seen low after release, before SDA rises, is collision.
// - Stop drives SDA low, releases SCL, waits SCL high, counts reload.
// - Baud counter clocks I2C and SPI master, reloading from reload reg except in the fixed-divide SPI modes.
// - Writing the shift buffer starts the baud counter.
// - When done, counter stops; I2C master holds SCL low, SPI clock returns to idle level.
// - Counter reloads twice per serial clock period.
// - Serial clock is clock over four times reload plus one.
// - SPI master samples at end of bit when sample bit set, else mid.
// - In I2C, sample bit set disables slew control, clear enables it.
// - SPI clock-edge bit set: data changes active-to-idle, else reverse.
// - In I2C, clock-edge bit selects SMBus input thresholds.
// - Data/address bit shows whether last byte was data.
// - Stop-seen bit set when Stop was last condition; zero after reset.
// - Start-seen bit set when Start was last condition; zero after reset.
// - Disabling the port clears stop-seen and start-seen.
// - Slave direction bit holds last matched R/W until Start, Stop, NACK.
// - Master direction bit reads one while transmitting.
// - OR of direction and sequence enables shows port not idle.
// - 10-bit slave sets update-address flag for software.
// - A bus collision during Stop sets the collision flag and returns port to idle.
// - Buffer-full set while an I2C master byte shifts or an SPI received byte waits, not during ACK/Stop.
module ssb_port (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output wire logic [7:0] reg_rdata,
  input  wire logic       scl_i,
  output wire logic       scl_o,
  output wire logic       scl_oe,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output wire logic       sda_oe,
  output wire logic       sdo,
  input  wire logic       sdi,
  input  wire logic       slv_addr_match,
  input  wire logic       slv_rw,
  input  wire logic       slv_byte_done,
  input  wire logic       slv_is_data,
  input  wire logic       slv_nack,
  input  wire logic       slv_ua_req,
  output wire logic       slew_ctl_en,
  output wire logic       smbus_levels_en,
  output wire logic       port_busy
);
  ssb_pkg::ssb_regs_t q_r;
  ssb_pkg::ssb_regs_t q_nxt;
  ssb_brg_if          brg ();
  logic [3:0]         mode;
  logic               en;
  logic               i2c_any;
  logic               i2c_mst;
  logic               spi_mst;
  logic               s10;
  logic               scl_s;
  logic               sda_s;
  logic               sdi_s;
  logic               start_det;
  logic               stop_det;
  logic               tx_refuse;
  logic               run;
  logic               col;
  logic               in_bit;
  logic [3:0]         last_bit;
  logic [7:0]         eff_reload;

  ssb_baud_gen u_brg (
    .mclk (mclk),
    .rst  (rst),
    .brg  (brg)
  );

  // -----------------------------------------------------------------
  // Mode decode and pin conditions
  // -----------------------------------------------------------------
  assign mode    = q_r.ctl1[3:0];
  assign en      = q_r.ctl1[ssb_pkg::C1_EN];
  assign i2c_mst = en & (mode == ssb_pkg::MODE_I2C_MST);
  assign spi_mst = en & ((mode == ssb_pkg::MODE_SPI_D4) |
                         (mode == ssb_pkg::MODE_SPI_D16) |
                         (mode == ssb_pkg::MODE_SPI_D64) |
                         (mode == ssb_pkg::MODE_SPI_BRG));
  assign i2c_any = en & ((mode == ssb_pkg::MODE_I2C_S7) |
                         (mode == ssb_pkg::MODE_I2C_S10) |
                         (mode == ssb_pkg::MODE_I2C_MST) |
                         (mode == ssb_pkg::MODE_I2C_FW) |
                         (mode == ssb_pkg::MODE_I2C_S7I) |
                         (mode == ssb_pkg::MODE_I2C_S10I));
  assign s10     = (mode == ssb_pkg::MODE_I2C_S10) |
                   (mode == ssb_pkg::MODE_I2C_S10I);
  assign scl_s   = q_r.scl_sync[1];
  assign sda_s   = q_r.sda_sync[1];
  assign sdi_s   = q_r.sdi_sync[1];
  assign start_det = scl_s & q_r.scl_prev & q_r.sda_prev & ~sda_s;
  assign stop_det  = scl_s & q_r.scl_prev & ~q_r.sda_prev & sda_s;
  assign port_busy = q_r.rw | q_r.ctl2[ssb_pkg::C2_SEN] |
                     q_r.ctl2[ssb_pkg::C2_RESTART_ENABLE_BIT] | q_r.ctl2[ssb_pkg::C2_PEN] |
                     q_r.ctl2[ssb_pkg::C2_RECEIVE_ENABLE_BIT] | q_r.ctl2[ssb_pkg::C2_ACK_ENABLE_BIT];
  assign tx_refuse = port_busy | (q_r.st != ssb_pkg::S_IDLE);
  assign last_bit  = i2c_mst ? ssb_pkg::ACK_BIT : ssb_pkg::DATA_LAST;

  // Reload source per mode
  always_comb begin
    case (mode)
      ssb_pkg::MODE_SPI_D4:  eff_reload = ssb_pkg::RELOAD_D4;
      ssb_pkg::MODE_SPI_D16: eff_reload = ssb_pkg::RELOAD_D16;
      ssb_pkg::MODE_SPI_D64: eff_reload = ssb_pkg::RELOAD_D64;
      default:               eff_reload = q_r.reload;
    endcase
  end
  assign brg.reload = eff_reload;
  assign brg.run    = run;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    run = 1'b0;
    col = 1'b0;
    in_bit = 1'b0;
    q_nxt.scl_sync = {q_r.scl_sync[0], scl_i};
    q_nxt.sda_sync = {q_r.sda_sync[0], sda_i};
    q_nxt.sdi_sync = {q_r.sdi_sync[0], sdi};
    q_nxt.scl_prev = scl_s;
    q_nxt.sda_prev = sda_s;
    // Bus conditions and slave status
    if (start_det) begin
      q_nxt.start_seen = 1'b1;
      q_nxt.stop_seen  = 1'b0;
      if (!i2c_mst) q_nxt.rw = 1'b0;
    end
    if (stop_det) begin
      q_nxt.stop_seen  = 1'b1;
      q_nxt.start_seen = 1'b0;
      if (!i2c_mst) q_nxt.rw = 1'b0;
    end
    if (slv_nack && !i2c_mst) q_nxt.rw = 1'b0;
    if (slv_addr_match && !i2c_mst) q_nxt.rw = slv_rw;
    if (slv_byte_done) q_nxt.da = slv_is_data;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ssb_pkg::REG_RELOAD: begin
          q_nxt.reload = reg_wdata;
          q_nxt.ua = 1'b0;
        end
        ssb_pkg::REG_BUF: begin
          if (tx_refuse && (i2c_mst || spi_mst)) begin
            q_nxt.ctl1[ssb_pkg::C1_WCOL] = 1'b1;
          end else begin
            q_nxt.buf_q = reg_wdata;
            if (i2c_mst || spi_mst) begin
              q_nxt.st    = ssb_pkg::S_XFER;
              q_nxt.shreg = reg_wdata;
              q_nxt.bitn  = 4'h0;
              q_nxt.half  = 1'b0;
              q_nxt.sdo   = reg_wdata[7];
              q_nxt.bf    = i2c_mst;
              if (i2c_mst) begin
                q_nxt.sda_low = ~reg_wdata[7];
                q_nxt.scl_low = 1'b1;
                q_nxt.rw = 1'b1;
              end
            end
          end
        end
        ssb_pkg::REG_CTL1: begin
          q_nxt.ctl1 = {q_r.ctl1[ssb_pkg::C1_WCOL] & reg_wdata[7],
                        q_r.ctl1[ssb_pkg::C1_OVF] & reg_wdata[6],
                        reg_wdata[5:0]};
        end
        ssb_pkg::REG_CTL2: begin
          q_nxt.ctl2[7] = reg_wdata[7];
          q_nxt.ctl2[5] = reg_wdata[5];
          if (!tx_refuse) begin
            q_nxt.ctl2[4:3] = reg_wdata[4:3];
            q_nxt.ctl2[1:0] = reg_wdata[1:0];
            if (reg_wdata[ssb_pkg::C2_PEN] && i2c_mst) begin
              q_nxt.ctl2[ssb_pkg::C2_PEN] = 1'b1;
              q_nxt.st = ssb_pkg::S_P_SDA;
              q_nxt.sda_low = 1'b1;
            end
          end
        end
        ssb_pkg::REG_CTL3:  q_nxt.ctl3 = {1'b0, reg_wdata[6:0]};
        ssb_pkg::REG_MASK:  q_nxt.mask = reg_wdata;
        ssb_pkg::REG_STAT: begin
          q_nxt.sample_phase_bit = reg_wdata[7];
          q_nxt.cke = reg_wdata[6];
        end
        ssb_pkg::REG_EVENT: begin
          if (reg_wdata[ssb_pkg::EV_BCOL]) q_nxt.bcol = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_rd && reg_addr == ssb_pkg::REG_BUF &&
        q_r.st == ssb_pkg::S_IDLE) begin
      q_nxt.bf = 1'b0;
    end
    if (slv_ua_req && s10 && en) q_nxt.ua = 1'b1;
    // Sequencer
    case (q_r.st)
      ssb_pkg::S_IDLE: run = 1'b0;
      ssb_pkg::S_XFER: begin
        // I2C high phase waits for SCL to read high (stretching)
        run = !(i2c_mst && q_r.half && !scl_s);
        if (brg.tick) begin
          if (!q_r.half) begin
            q_nxt.half = 1'b1;
            q_nxt.scl_low = 1'b0;
            if (!q_r.sample_phase_bit) q_nxt.sbit = sdi_s;
          end else begin
            q_nxt.half = 1'b0;
            in_bit = i2c_mst ? sda_s : (q_r.sample_phase_bit ? sdi_s : q_r.sbit);
            if (q_r.bitn == last_bit) begin
              q_nxt.st = ssb_pkg::S_IDLE;
              if (i2c_mst) begin
                q_nxt.ctl2[ssb_pkg::C2_ACKSTAT] = sda_s;
                q_nxt.scl_low = 1'b1;
                q_nxt.sda_low = 1'b0;
                q_nxt.rw = 1'b0;
              end else begin
                q_nxt.buf_q = {q_r.shreg[6:0], in_bit};
                q_nxt.bf = 1'b1;
              end
            end else begin
              q_nxt.bitn  = q_r.bitn + 4'h1;
              q_nxt.shreg = {q_r.shreg[6:0], in_bit};
              q_nxt.sdo   = q_r.shreg[6];
              if (i2c_mst) begin
                q_nxt.scl_low = 1'b1;
                if (q_r.bitn == ssb_pkg::DATA_LAST) begin
                  q_nxt.sda_low = 1'b0;
                  q_nxt.bf = 1'b0;
                end else begin
                  q_nxt.sda_low = ~q_r.shreg[6];
                end
              end
            end
          end
        end
      end
      ssb_pkg::S_P_SDA: begin
        if (!sda_s) begin
          q_nxt.scl_low = 1'b0;
          q_nxt.st = ssb_pkg::S_P_SCL;
        end
      end
      ssb_pkg::S_P_SCL: begin
        if (scl_s) q_nxt.st = ssb_pkg::S_P_HOLD;
      end
      ssb_pkg::S_P_HOLD: begin
        run = 1'b1;
        if (!scl_s) begin
          col = 1'b1;
        end else if (brg.tick) begin
          q_nxt.sda_low = 1'b0;
          q_nxt.st = ssb_pkg::S_P_CHK;
        end
      end
      ssb_pkg::S_P_CHK: begin
        run = 1'b1;
        if (brg.tick) begin
          if (!sda_s) begin
            col = 1'b1;
          end else begin
            q_nxt.ctl2[ssb_pkg::C2_PEN] = 1'b0;
            q_nxt.st = ssb_pkg::S_IDLE;
          end
        end
      end
      default: q_nxt.st = ssb_pkg::S_IDLE;
    endcase
    if (col) begin
      q_nxt.bcol = 1'b1;
      q_nxt.sda_low = 1'b0;
      q_nxt.scl_low = 1'b0;
      q_nxt.ctl2[ssb_pkg::C2_PEN] = 1'b0;
      q_nxt.st = ssb_pkg::S_IDLE;
    end
    if (!en) begin
      q_nxt.start_seen = 1'b0;
      q_nxt.stop_seen  = 1'b0;
      q_nxt.st = ssb_pkg::S_IDLE;
      q_nxt.sda_low = 1'b0;
      q_nxt.scl_low = 1'b0;
      q_nxt.rw = 1'b0;
    end
    q_nxt.sck = q_nxt.ctl1[ssb_pkg::C1_CKP];
    if (q_nxt.st == ssb_pkg::S_XFER) begin
      q_nxt.sck = q_nxt.ctl1[ssb_pkg::C1_CKP] ^
                  (q_r.cke ? q_nxt.half : ~q_nxt.half);
    end
    // Read data for one cycle only
    q_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ssb_pkg::REG_RELOAD: q_nxt.rdata = q_r.reload;
        ssb_pkg::REG_BUF:    q_nxt.rdata = q_r.buf_q;
        ssb_pkg::REG_CTL1:   q_nxt.rdata = q_r.ctl1;
        ssb_pkg::REG_CTL2:   q_nxt.rdata = q_r.ctl2;
        ssb_pkg::REG_CTL3:   q_nxt.rdata = q_r.ctl3;
        ssb_pkg::REG_MASK:   q_nxt.rdata = q_r.mask;
        ssb_pkg::REG_STAT:   q_nxt.rdata = {q_r.sample_phase_bit, q_r.cke, q_r.da,
                               q_r.stop_seen, q_r.start_seen, q_r.rw,
                               q_r.ua, q_r.bf};
        ssb_pkg::REG_EVENT:  q_nxt.rdata = {7'h00, q_r.bcol};
        default:             q_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.scl_sync <= 2'h3;
      q_r.sda_sync <= 2'h3;
      q_r.scl_prev <= 1'b1;
      q_r.sda_prev <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign reg_rdata       = q_r.rdata;
  assign scl_o           = spi_mst ? q_r.sck : 1'b0;
  assign scl_oe          = spi_mst | q_r.scl_low;
  assign sda_o           = 1'b0;
  assign sda_oe          = q_r.sda_low;
  assign sdo             = q_r.sdo;
  assign slew_ctl_en     = i2c_any & ~q_r.sample_phase_bit;
  assign smbus_levels_en = i2c_any & q_r.cke;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  logic [9:0] gap_cnt;
  logic       gap_ok;
  logic [7:0] gap_rl;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_cnt <= 10'h000;
      gap_ok  <= 1'b0;
      gap_rl  <= 8'h00;
    end else begin
      gap_rl  <= brg.reload;
      gap_cnt <= brg.tick ? 10'h000 : gap_cnt + 10'h001;
      if (!brg.run || brg.reload != gap_rl) gap_ok <= 1'b0;
      else if (brg.tick) gap_ok <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_stop_sda_col;
    (q_r.st == ssb_pkg::S_P_CHK) && brg.tick && !sda_s && en
      |=> q_r.bcol && (q_r.st == ssb_pkg::S_IDLE);
  endproperty
  a_stop_sda_col: assert property (p_stop_sda_col)
    else $error("stop sda collision missed");
  property p_stop_scl_col;
    (q_r.st == ssb_pkg::S_P_HOLD) && !scl_s && en
      |=> q_r.bcol && !sda_oe && !scl_oe;
  endproperty
  a_stop_scl_col: assert property (p_stop_scl_col)
    else $error("stop scl collision missed");
  property p_stop_scl_rel;
    (q_r.st == ssb_pkg::S_P_SDA) && !sda_s && en
      |=> (q_r.st == ssb_pkg::S_P_SCL) && !scl_oe;
  endproperty
  a_stop_scl_rel: assert property (p_stop_scl_rel)
    else $error("scl not released after sda low");
  property p_buf_start;
    reg_wr && reg_addr == ssb_pkg::REG_BUF && i2c_mst && !tx_refuse
      |=> (q_r.st == ssb_pkg::S_XFER) ##1 brg.run;
  endproperty
  a_buf_start: assert property (p_buf_start)
    else $error("buffer write did not start counter");
  property p_idle_stop;
    q_r.st == ssb_pkg::S_IDLE |-> !brg.run;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("counter runs while idle");
  property p_half_gap;
    brg.tick && gap_ok && brg.reload == gap_rl
      |-> gap_cnt == {1'b0, brg.reload, 1'b1};
  endproperty
  a_half_gap: assert property (p_half_gap)
    else $error("half period length wrong");
  property p_seen_clr;
    !en |=> !q_r.stop_seen && !q_r.start_seen;
  endproperty
  a_seen_clr: assert property (p_seen_clr)
    else $error("seen bits kept while disabled");
  property p_start_seen;
    start_det && en && !(reg_wr && reg_addr == ssb_pkg::REG_CTL1)
      |=> q_r.start_seen && !q_r.stop_seen;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start not recorded");
  property p_tx_bf;
    (q_r.st == ssb_pkg::S_XFER) && i2c_mst && q_r.bitn < ssb_pkg::ACK_BIT
      |-> q_r.bf && q_r.rw;
  endproperty
  a_tx_bf: assert property (p_tx_bf)
    else $error("full or direction low during transmit");
  property p_col_rel;
    $rose(q_r.bcol) |-> !q_r.ctl2[ssb_pkg::C2_PEN] && !sda_oe && !scl_oe
      && (q_r.st == ssb_pkg::S_IDLE);
  endproperty
  a_col_rel: assert property (p_col_rel)
    else $error("collision left lines or stop enable");

  c_stop_done: cover property ((q_r.st == ssb_pkg::S_P_CHK) ##1
                               (q_r.st == ssb_pkg::S_IDLE) && !q_r.bcol);
  c_col_case1: cover property ((q_r.st == ssb_pkg::S_P_CHK) ##1 $rose(q_r.bcol));
  c_col_case2: cover property ((q_r.st == ssb_pkg::S_P_HOLD) ##1 $rose(q_r.bcol));
  c_spi_done:  cover property (spi_mst && $rose(q_r.bf));
endmodule : ssb_port

// file: verif/ssb_bus_model.sv
/*
  Open-drain I2C bus with pull-ups and a rival master that can pull
  SDA low (fault 1) or grab SCL during a Stop (fault 2).
  Assumes the pad enables of ssb_port, all on mclk.
*/
`timescale 1ns/1ns
module ssb_bus_model (
  input  wire logic       mclk,
  input  wire logic       scl_o,
  input  wire logic       scl_oe,
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  input  wire logic [1:0] fault,
  output wire logic       scl,
  output wire logic       sda
);
  logic [3:0] hold_r;
  // Cycles since SCL released with SDA held low
  always_ff @(posedge mclk) begin
    hold_r <= (sda_oe && !scl_oe) ? hold_r + {3'h0, hold_r != 4'hF} : 4'h0;
  end
  assign scl = !(scl_oe && !scl_o) && !(fault == 2'h2 && hold_r >= 4'h5);
  assign sda = !(sda_oe && !sda_o) && fault != 2'h1;
endmodule : ssb_bus_model

// file: verif/tb_top.sv
/*
  Bench for ssb_port: register tasks, baud timing, Stop collisions
  and status bits. Assumes ssb_bus_model resolves the pins.
*/
`timescale 1ns/1ns
module tb_top;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic [2:0] ra   = 3'h0;
  logic [7:0] wd   = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [5:0] sl   = 6'h00;
  logic [1:0] fault = 2'h0;
  wire  [7:0] rdat;
  wire        scl, sda, so, soe, dao, daoe, sdo, slew, smb, busy;
  int         mismatches = 0;
  int         n_tests = 0;
  int         n;
  always #5 mclk = ~mclk;
  ssb_port u_dut (.mclk(mclk), .rst(rst), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .scl_i(scl),
    .scl_o(so), .scl_oe(soe), .sda_i(sda), .sda_o(dao), .sda_oe(daoe),
    .sdo(sdo), .sdi(sdo), .slv_addr_match(sl[5]), .slv_rw(sl[4]),
    .slv_byte_done(sl[3]), .slv_is_data(sl[2]), .slv_nack(sl[1]),
    .slv_ua_req(sl[0]), .slew_ctl_en(slew), .smbus_levels_en(smb),
    .port_busy(busy));
  ssb_bus_model u_bus (.mclk(mclk), .scl_o(so), .scl_oe(soe), .sda_o(dao),
    .sda_oe(daoe), .fault(fault), .scl(scl), .sda(sda));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    ra <= a; wd <= v; wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask : wr
  task rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
          input string s);
    @(posedge mclk);
    ra <= a; rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    chk(s, e, rdat & m);
  endtask : rc
  task idle;
    @(negedge mclk);
    while (busy !== 1'b0) @(negedge mclk);
  endtask : idle
  task pulse(input logic [5:0] v);
    @(posedge mclk);
    sl <= v;
    @(posedge mclk);
    sl <= 6'h00;
  endtask : pulse
  // Length of one high run of the clock drive
  task meas(input logic spi, input logic [7:0] e);
    n = 0;
    while ((spi ? so : soe) !== 1'b0) @(negedge mclk);
    while ((spi ? so : soe) !== 1'b1) @(negedge mclk);
    while ((spi ? so : soe) === 1'b1) begin
      n++;
      @(negedge mclk);
    end
    chk("half period", e, n[7:0]);
  endtask : meas
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rc(ssb_pkg::REG_STAT, 8'hFF, 8'h00, "status reset");
    wr(ssb_pkg::REG_RELOAD, 8'h03);
    wr(ssb_pkg::REG_CTL1, 8'h28);
    wr(ssb_pkg::REG_STAT, 8'h40);
    @(negedge mclk);
    chk("slew", 8'h01, {7'h00, slew});
    chk("smbus", 8'h01, {7'h00, smb});
    wr(ssb_pkg::REG_BUF, 8'hA5);
    rc(ssb_pkg::REG_STAT, 8'h07, 8'h05, "bf dir");
    chk("busy", 8'h01, {7'h00, busy});
    meas(1'b0, 8'h08);
    idle;
    chk("scl held", 8'h01, {7'h00, soe});
    rc(ssb_pkg::REG_STAT, 8'h07, 8'h00, "byte done");
    wr(ssb_pkg::REG_CTL2, 8'h04);
    idle;
    rc(ssb_pkg::REG_EVENT, 8'h01, 8'h00, "clean stop");
    rc(ssb_pkg::REG_STAT, 8'h18, 8'h10, "stop seen");
    fault <= 2'h1;
    wr(ssb_pkg::REG_CTL2, 8'h04);
    idle;
    rc(ssb_pkg::REG_EVENT, 8'h01, 8'h01, "sda coll");
    rc(ssb_pkg::REG_CTL2, 8'h04, 8'h00, "stop bit");
    chk("lines", 8'h00, {6'h00, soe, daoe});
    wr(ssb_pkg::REG_EVENT, 8'h01);
    fault <= 2'h0;
    rc(ssb_pkg::REG_EVENT, 8'h01, 8'h00, "flag clear");
    fault <= 2'h2;
    wr(ssb_pkg::REG_CTL2, 8'h04);
    idle;
    rc(ssb_pkg::REG_EVENT, 8'h01, 8'h01, "scl coll");
    fault <= 2'h0;
    rc(ssb_pkg::REG_STAT, 8'h18, 8'h08, "start seen");
    wr(ssb_pkg::REG_CTL1, 8'h08);
    rc(ssb_pkg::REG_STAT, 8'h18, 8'h00, "disable");
    wr(ssb_pkg::REG_CTL1, 8'h27);
    pulse(6'h3D);
    rc(ssb_pkg::REG_STAT, 8'h26, 8'h26, "slave");
    pulse(6'h0A);
    rc(ssb_pkg::REG_STAT, 8'h24, 8'h00, "nack");
    wr(ssb_pkg::REG_CTL1, 8'h2A);
    wr(ssb_pkg::REG_BUF, 8'h5A);
    meas(1'b1, 8'h08);
    repeat (150) @(posedge mclk);
    rc(ssb_pkg::REG_STAT, 8'h01, 8'h01, "spi full");
    rc(ssb_pkg::REG_BUF, 8'hFF, 8'h5A, "spi loop");
    end_sim();
  end
endmodule : tb_top
